// ===== hdl/rlc_top.sv
// rlc_top: dummy latency selection, dummy cycle counting and the extended read register
`timescale 1ns/1ns
`default_nettype none

// Operation
// - nonzero dummy field gives a latency of exactly that many serial clocks, 1 to 15.
// - a zero dummy field selects a per-command default latency, never zero.
// - defaults: single 8 spi, 6 qpi; dual/quad out 8; dual io 4; quad io 6.
// - decode fast, dual, quad read opcodes and their double-rate variants.
// - unique id, parameter table and info row reads use single-lane latency.
// - dual io double-rate read is refused while in four-lane instruction mode.
// - extended register bits 7 to 5 select the output drive strength.
// - bits 3 to 0 are read-only status; extended writes leave them alone.
// - opcode 85h writes the persistent copy, 83h the temporary copy.
// - bit 4 reserved; default has bits 7 to 4 one, 3 to 0 zero.
// - at power-up the temporary copy loads from the persistent one first.
// - busy bit reads one while an internal operation runs, else zero.
module rlc_top
   import rlc_pkg::*;
(
   // clock, reset, enable
   input  wire  logic       CLK_SYS,
   input  wire  logic       RST,
   input  wire  logic       CE,
   // serial link pins
   input  wire  logic       SCK,
   input  wire  logic       CS_N,
   // command decoder
   input  wire  logic       CMD_VALID,
   input  wire  logic [7:0] CMD_OPCODE,
   input  wire  logic       QPI_MODE,
   input  wire  logic       ADDR_DONE,
   input  wire  logic [3:0] DUMMY_CFG,
   input  wire  logic       EXT_WR_VALID,
   input  wire  logic [7:0] EXT_WR_DATA,
   // internal operation status
   input  wire  rlc_stat_t  OP_STATUS,
   // outputs
   output logic             READY,
   output logic             CMD_REJECT,
   output logic             DUMMY_ACTIVE,
   output logic             DATA_START,
   output logic [3:0]       DUMMY_LEFT,
   output logic [7:0]       EXT_REG,
   output logic [7:0]       EXT_PERSIST,
   output logic [2:0]       DRIVE_STRENGTH
);

   typedef enum {ST_IDLE, ST_CMD, ST_DUMMY, ST_DATA} rlc_state_t;

   rlc_state_t state_ff;
   rlc_state_t nxt_state;
   logic       sck_s1_ff;
   logic       sck_s2_ff;
   logic       sck_s3_ff;
   logic       csn_s1_ff;
   logic       csn_s2_ff;
   logic       sck_rise;
   logic       ready_ff;
   logic [7:0] op_ff;
   logic       qpi_ff;
   logic       read_ok;
   logic       reject_ff;
   logic [3:0] cnt_ff;
   logic [3:0] nxt_cnt;
   logic       start_ff;
   logic [2:0] drive_ff;
   logic [2:0] drive_nv_ff;
   rlc_ext_t   ext_rd_ff;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers; only the second stage and beyond feed logic
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         sck_s1_ff <= 1'b0;
         sck_s2_ff <= 1'b0;
         sck_s3_ff <= 1'b0;
         csn_s1_ff <= 1'b1;
         csn_s2_ff <= 1'b1;
      end else if (CE) begin
         sck_s1_ff <= SCK;
         sck_s2_ff <= sck_s1_ff;
         sck_s3_ff <= sck_s2_ff;
         csn_s1_ff <= CS_N;
         csn_s2_ff <= csn_s1_ff;
      end
   end

   assign sck_rise = sck_s2_ff & ~sck_s3_ff;

   ////////////////////////////////////////////////////////////////////////////
   // power-up load: one enabled cycle after reset copies persistent to temporary
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         ready_ff <= 1'b0;
      end else if (CE) begin
         ready_ff <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // opcode latch; the dual io double-rate form is not a command in qpi
   assign read_ok = rlc_is_read(op_ff) &&
                    !(qpi_ff && (op_ff == OP_DIO_DTR_A || op_ff == OP_DIO_DTR_B));

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         op_ff     <= 8'h00;
         qpi_ff    <= 1'b0;
         reject_ff <= 1'b0;
      end else if (CE) begin
         reject_ff <= 1'b0;
         // only an opcode that opens a frame is latched, so a stray strobe cannot retarget a running read
         if (CMD_VALID && ready_ff && state_ff == ST_IDLE && !csn_s2_ff) begin
            op_ff     <= CMD_OPCODE;
            qpi_ff    <= QPI_MODE;
            reject_ff <= QPI_MODE && (CMD_OPCODE == OP_DIO_DTR_A || CMD_OPCODE == OP_DIO_DTR_B);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read sequencer; chip select high aborts any phase
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      case (state_ff)
         ST_IDLE: begin
            if (CMD_VALID && ready_ff) begin
               nxt_state = ST_CMD;
            end
         end
         ST_CMD: begin
            if (ADDR_DONE) begin
               if (read_ok) begin
                  nxt_state = ST_DUMMY;
                  nxt_cnt   = rlc_latency(op_ff, qpi_ff, DUMMY_CFG);
               end else begin
                  nxt_state = ST_IDLE;
               end
            end
         end
         ST_DUMMY: begin
            if (sck_rise) begin
               nxt_cnt = cnt_ff - DUMMY_LAST;
               if (cnt_ff == DUMMY_LAST) begin
                  nxt_state = ST_DATA;
               end
            end
         end
         ST_DATA: begin
            nxt_state = ST_DATA;
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
      if (csn_s2_ff) begin
         nxt_state = ST_IDLE;
         nxt_cnt   = DUMMY_ZERO;
      end
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         state_ff <= ST_IDLE;
         cnt_ff   <= DUMMY_ZERO;
         start_ff <= 1'b0;
      end else if (CE) begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
         start_ff <= (state_ff == ST_DUMMY) && (nxt_state == ST_DATA);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // extended register copies; only the drive field is writable
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         drive_nv_ff <= EXT_DRIVE_RST;
         drive_ff    <= EXT_DRIVE_RST;
      end else if (CE) begin
         if (!ready_ff) begin
            drive_ff <= drive_nv_ff;
         end else if (EXT_WR_VALID && state_ff == ST_CMD && op_ff == OP_EXT_TEMP) begin
            drive_ff <= EXT_WR_DATA[7:5];
         end
         if (ready_ff && EXT_WR_VALID && state_ff == ST_CMD && op_ff == OP_EXT_PERSIST) begin
            drive_nv_ff <= EXT_WR_DATA[7:5];
         end
      end
   end

   // read view: status bits follow the live flags, never the write data
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         ext_rd_ff <= rlc_ext_t'(EXT_RST_VAL);
      end else if (CE) begin
         ext_rd_ff <= '{drive: drive_ff, rsvd: EXT_RSVD_VAL, erase_err: OP_STATUS.erase_err,
                        prog_err: OP_STATUS.prog_err, prot_err: OP_STATUS.prot_err,
                        busy: OP_STATUS.busy};
      end
   end

   assign READY          = ready_ff;
   assign CMD_REJECT     = reject_ff;
   assign DUMMY_ACTIVE   = (state_ff == ST_DUMMY);
   assign DATA_START     = start_ff;
   assign DUMMY_LEFT     = cnt_ff;
   assign EXT_REG        = ext_rd_ff;
   assign EXT_PERSIST    = {drive_nv_ff, EXT_RSVD_VAL, 4'h0};
   assign DRIVE_STRENGTH = drive_ff;

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   a_explicit_count: assert property (@(posedge CLK_SYS) disable iff (RST)
      (CE && !csn_s2_ff && state_ff == ST_CMD && ADDR_DONE && read_ok && DUMMY_CFG != DUMMY_ZERO)
      |=> (cnt_ff == $past(DUMMY_CFG)))
      else $error("explicit dummy count not loaded");

   a_zero_default: assert property (@(posedge CLK_SYS) disable iff (RST)
      (CE && !csn_s2_ff && state_ff == ST_CMD && ADDR_DONE && read_ok) |=> (cnt_ff != DUMMY_ZERO))
      else $error("zero dummy latency loaded");

   a_dual_io_dflt: assert property (@(posedge CLK_SYS) disable iff (RST)
      (CE && !csn_s2_ff && state_ff == ST_CMD && ADDR_DONE && DUMMY_CFG == DUMMY_ZERO && op_ff == OP_DUAL_IO_A)
      |=> (cnt_ff == DFLT_DUAL_IO))
      else $error("dual io default latency wrong");

   a_uid_latency: assert property (@(posedge CLK_SYS) disable iff (RST)
      (CE && !csn_s2_ff && state_ff == ST_CMD && ADDR_DONE && DUMMY_CFG == DUMMY_ZERO && op_ff == OP_RD_UID)
      |=> (cnt_ff == (qpi_ff ? DFLT_SGL_QPI : DFLT_SGL_SPI)))
      else $error("id read latency differs from fast read");

   a_dtr_qpi_block: assert property (@(posedge CLK_SYS) disable iff (RST)
      (CE && state_ff == ST_CMD && ADDR_DONE && qpi_ff && op_ff == OP_DIO_DTR_B) |=> (state_ff != ST_DUMMY))
      else $error("dual io double-rate read accepted in qpi");

   a_temp_write: assert property (@(posedge CLK_SYS) disable iff (RST)
      (CE && ready_ff && EXT_WR_VALID && state_ff == ST_CMD && op_ff == OP_EXT_TEMP)
      |=> (DRIVE_STRENGTH == $past(EXT_WR_DATA[7:5])) && $stable(drive_nv_ff))
      else $error("temporary extended write misrouted");

   // sampled reset in the antecedent: at the release edge the flops still take their reset value
   a_status_live: assert property (@(posedge CLK_SYS) disable iff (RST)
      (!RST && CE) |=> (EXT_REG[3:0] == $past(OP_STATUS)) && (EXT_REG[4] == EXT_RSVD_VAL))
      else $error("status bits not tracking operation flags");

   a_busy_flag: assert property (@(posedge CLK_SYS) disable iff (RST)
      (!RST && CE && OP_STATUS.busy) |=> EXT_REG[0])
      else $error("busy flag not shown");

   a_powerup_load: assert property (@(posedge CLK_SYS) disable iff (RST)
      (!RST && CE && !ready_ff) |=> (ready_ff && drive_ff == $past(drive_nv_ff)))
      else $error("temporary copy not loaded at power-up");

   a_data_after_dummy: assert property (@(posedge CLK_SYS) disable iff (RST)
      (CE && state_ff == ST_DUMMY && sck_rise && cnt_ff == DUMMY_LAST && !csn_s2_ff) |=> DATA_START)
      else $error("data start missing after last dummy clock");

endmodule // rlc_top
`default_nettype wire

// ===== hdl/rlc_pkg.sv
// rlc_pkg: constants, register layout and helpers of the read latency and drive configuration block
`default_nettype none
package rlc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // read command opcodes, normal and double-rate forms
   localparam logic [7:0] OP_FAST_RD_A  = 8'h0b;
   localparam logic [7:0] OP_FAST_RD_B  = 8'h0c;
   localparam logic [7:0] OP_DUAL_OUT_A = 8'h3b;
   localparam logic [7:0] OP_DUAL_OUT_B = 8'h3c;
   localparam logic [7:0] OP_DUAL_IO_A  = 8'hbb;
   localparam logic [7:0] OP_DUAL_IO_B  = 8'hbc;
   localparam logic [7:0] OP_QUAD_OUT_A = 8'h6b;
   localparam logic [7:0] OP_QUAD_OUT_B = 8'h6c;
   localparam logic [7:0] OP_QUAD_IO_A  = 8'heb;
   localparam logic [7:0] OP_QUAD_IO_B  = 8'hec;
   localparam logic [7:0] OP_SGL_DTR_A  = 8'h0d;
   localparam logic [7:0] OP_SGL_DTR_B  = 8'h0e;
   localparam logic [7:0] OP_DIO_DTR_A  = 8'hbd;
   localparam logic [7:0] OP_DIO_DTR_B  = 8'hbe;
   localparam logic [7:0] OP_QIO_DTR_A  = 8'hed;
   localparam logic [7:0] OP_QIO_DTR_B  = 8'hee;
   // id, parameter table and info row reads share the single-lane latency
   localparam logic [7:0] OP_RD_UID     = 8'h4b;
   localparam logic [7:0] OP_RD_PARAM   = 8'h5a;
   localparam logic [7:0] OP_RD_INFO    = 8'h68;
   // extended register writes
   localparam logic [7:0] OP_EXT_PERSIST = 8'h85;
   localparam logic [7:0] OP_EXT_TEMP    = 8'h83;

   ////////////////////////////////////////////////////////////////////////////
   // default latencies when the dummy field is zero
   localparam logic [3:0] DUMMY_ZERO     = 4'h0;
   localparam logic [3:0] DUMMY_LAST     = 4'h1;
   localparam logic [3:0] DFLT_SGL_SPI   = 4'h8;
   localparam logic [3:0] DFLT_SGL_QPI   = 4'h6;
   localparam logic [3:0] DFLT_OUT_X     = 4'h8;
   localparam logic [3:0] DFLT_DUAL_IO   = 4'h4;
   localparam logic [3:0] DFLT_QUAD_IO   = 4'h6;

   ////////////////////////////////////////////////////////////////////////////
   // extended read register layout
   typedef struct packed {
      logic [2:0] drive;      // drive_strength_bit2..0
      logic       rsvd;       // ext_reserved_bit
      logic       erase_err;
      logic       prog_err;
      logic       prot_err;   // protection_fault_flag
      logic       busy;       // op_in_progress
   } rlc_ext_t;

   typedef struct packed {
      logic erase_err;
      logic prog_err;
      logic prot_err;
      logic busy;
   } rlc_stat_t;

   localparam logic [2:0] EXT_DRIVE_RST = 3'h7;
   localparam logic       EXT_RSVD_VAL  = 1'b1;
   localparam logic [7:0] EXT_RST_VAL   = 8'hf0;

   ////////////////////////////////////////////////////////////////////////////
   // true for every read opcode that has a dummy phase
   function automatic logic rlc_is_read(input logic [7:0] op);
      case (op)
         OP_FAST_RD_A, OP_FAST_RD_B, OP_DUAL_OUT_A, OP_DUAL_OUT_B,
         OP_DUAL_IO_A, OP_DUAL_IO_B, OP_QUAD_OUT_A, OP_QUAD_OUT_B,
         OP_QUAD_IO_A, OP_QUAD_IO_B, OP_SGL_DTR_A, OP_SGL_DTR_B,
         OP_DIO_DTR_A, OP_DIO_DTR_B, OP_QIO_DTR_A, OP_QIO_DTR_B,
         OP_RD_UID, OP_RD_PARAM, OP_RD_INFO: rlc_is_read = 1'b1;
         default:                             rlc_is_read = 1'b0;
      endcase
   endfunction

   // latency for an opcode: the configured field, else the per-command default
   function automatic logic [3:0] rlc_latency(input logic [7:0] op, input logic qpi, input logic [3:0] cfg);
      logic [3:0] dflt;
      case (op)
         OP_FAST_RD_A, OP_FAST_RD_B, OP_SGL_DTR_A, OP_SGL_DTR_B,
         OP_RD_UID, OP_RD_PARAM, OP_RD_INFO: dflt = qpi ? DFLT_SGL_QPI : DFLT_SGL_SPI;
         OP_DUAL_IO_A, OP_DUAL_IO_B, OP_DIO_DTR_A, OP_DIO_DTR_B: dflt = DFLT_DUAL_IO;
         OP_QUAD_IO_A, OP_QUAD_IO_B, OP_QIO_DTR_A, OP_QIO_DTR_B: dflt = DFLT_QUAD_IO;
         default: dflt = DFLT_OUT_X;
      endcase
      rlc_latency = (cfg != DUMMY_ZERO) ? cfg : dflt;
   endfunction

endpackage
`default_nettype wire

// ===== sim/rlc_host_model.sv
// rlc_host_model: serial host that frames a transfer and clocks the dummy phase
`timescale 1ns/1ns
`default_nettype none
module rlc_host_model (
   // bench requests
   input  wire logic sel,
   input  wire logic run,
   // serial link pins
   output var  logic sck_o,
   output var  logic cs_n_o
);
   ////////////////////////////////////////////////////////////////////////////
   // chip select follows the bench's frame request
   assign cs_n_o = ~sel;

   // 160 ns serial clock, parked low outside a frame so no stray edge is counted
   // the bench picks the dummy count; the host only clocks, never drives data lines here
   initial sck_o = 1'b0;
   always #80 sck_o = (run && sel) ? ~sck_o : 1'b0;
endmodule // rlc_host_model
`default_nettype wire

// ===== sim/rlc_top_tb_top.sv
// rlc_top_tb_top: self-checking bench for the latency and drive configuration block
`timescale 1ns/1ns
`default_nettype none
module rlc_top_tb_top;
   import rlc_pkg::*;
   logic       clk_sys      = 1'b0;
   logic       rst          = 1'b1;
   logic       ce           = 1'b1;
   logic       sel          = 1'b0;
   logic       run          = 1'b0;
   logic       cmd_valid    = 1'b0;
   logic [7:0] cmd_opcode   = 8'h00;
   logic       qpi_mode     = 1'b0;
   logic       addr_done    = 1'b0;
   logic [3:0] dummy_cfg    = 4'h0;
   logic       ext_wr_valid = 1'b0;
   logic [7:0] ext_wr_data  = 8'h00;
   rlc_stat_t  op_status    = 4'h0;
   wire  logic sck, cs_n, ready, cmd_reject, dummy_active, data_start;
   wire  logic [3:0] dummy_left;
   wire  logic [7:0] ext_reg, ext_persist;
   wire  logic [2:0] drive_strength;
   int         errors       = 0;
   int         checks       = 0;
   int         sck_cnt      = 0;
   // default-latency table: opcode, four-lane mode, expected dummy clocks
   logic [7:0] ops  [19] = '{8'h0b, 8'h0c, 8'h3b, 8'h3c, 8'hbb, 8'hbc, 8'h6b, 8'h6c, 8'heb, 8'hec,
                             8'h0d, 8'h0e, 8'hbd, 8'hbe, 8'hed, 8'hee, 8'h4b, 8'h5a, 8'h68};
   logic       qpis [19] = '{0, 1, 0, 0, 0, 0, 0, 0, 0, 1, 0, 1, 0, 0, 0, 1, 0, 0, 1};
   logic [3:0] exps [19] = '{8, 6, 8, 8, 4, 4, 8, 8, 6, 6, 8, 6, 4, 4, 6, 6, 8, 8, 6};

   always #5 clk_sys = ~clk_sys;

   ////////////////////////////////////////////////////////////////////////////
   rlc_host_model HOST (.sel(sel), .run(run), .sck_o(sck), .cs_n_o(cs_n));

   rlc_top DUT (
      .CLK_SYS(clk_sys), .RST(rst), .CE(ce), .SCK(sck), .CS_N(cs_n),
      .CMD_VALID(cmd_valid), .CMD_OPCODE(cmd_opcode), .QPI_MODE(qpi_mode),
      .ADDR_DONE(addr_done), .DUMMY_CFG(dummy_cfg), .EXT_WR_VALID(ext_wr_valid),
      .EXT_WR_DATA(ext_wr_data), .OP_STATUS(op_status), .READY(ready),
      .CMD_REJECT(cmd_reject), .DUMMY_ACTIVE(dummy_active), .DATA_START(data_start),
      .DUMMY_LEFT(dummy_left), .EXT_REG(ext_reg), .EXT_PERSIST(ext_persist),
      .DRIVE_STRENGTH(drive_strength)
   );

   // count serial clocks that land inside the dummy phase
   always @(posedge sck) begin
      if (dummy_active === 1'b1) begin
         sck_cnt++;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      if (errors == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // open a frame, wait out the pin synchronisers, then pulse the opcode
   task automatic send_cmd(input logic [7:0] op, input logic qpi);
      sel <= 1'b1;
      tick(4);
      cmd_valid <= 1'b1;
      cmd_opcode <= op;
      qpi_mode <= qpi;
      tick(1);
      cmd_valid <= 1'b0;
   endtask

   // one read: refusal, loaded count, clocks counted until data starts
   task automatic rd(input logic [7:0] op, input logic qpi, input logic [3:0] cfg, input logic [3:0] exp,
                     input logic rej);
      int   n;
      logic seen_rej;
      n = 0;
      dummy_cfg <= cfg;
      send_cmd(op, qpi);
      #1 seen_rej = cmd_reject;
      tick(1);
      #1 seen_rej = seen_rej | cmd_reject;
      chk({7'h0, seen_rej}, {7'h0, rej});
      tick(1);
      addr_done <= 1'b1;
      tick(1);
      addr_done <= 1'b0;
      tick(1);
      #1 chk({3'h0, dummy_active, dummy_left}, {3'h0, !rej, rej ? 4'h0 : exp});
      if (!rej) begin
         sck_cnt = 0;
         tick(1);
         run <= 1'b1;
         while (data_start !== 1'b1 && n < 400) begin
            @(negedge clk_sys);
            n++;
         end
         chk({7'h0, data_start}, 8'h01);
         chk(sck_cnt[7:0], {4'h0, exp});
      end
      tick(1);
      run <= 1'b0;
      sel <= 1'b0;
      tick(6);
   endtask

   // extended register write: opcode then one data byte in the same frame
   task automatic ext_wr(input logic [7:0] op, input logic [7:0] d);
      send_cmd(op, 1'b0);
      ext_wr_valid <= 1'b1;
      ext_wr_data <= d;
      tick(1);
      ext_wr_valid <= 1'b0;
      tick(3);
      sel <= 1'b0;
      tick(6);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // watchdog: the full sequence needs well under 150 us
   initial begin
      #400000;
      errors++;
      end_sim();
   end

   initial begin
      tick(4);
      rst <= 1'b0;
      tick(4);
      chk({7'h0, ready}, 8'h01);
      chk(ext_reg, 8'hf0);
      chk(ext_persist, 8'hf0);
      chk({5'h0, drive_strength}, 8'h07);
      for (int i = 0; i < 19; i++) begin
         rd(ops[i], qpis[i], 4'h0, exps[i], 1'b0);
      end
      rd(8'h0b, 1'b0, 4'h1, 4'h1, 1'b0);
      rd(8'heb, 1'b1, 4'hd, 4'hd, 1'b0);
      rd(8'h3b, 1'b0, 4'hf, 4'hf, 1'b0);
      rd(8'hbd, 1'b1, 4'h0, 4'h0, 1'b1);
      rd(8'hbe, 1'b1, 4'h5, 4'h0, 1'b1);
      ext_wr(8'h83, 8'ha0);
      chk({5'h0, drive_strength}, 8'h05);
      chk(ext_reg, 8'hb0);
      ext_wr(8'h83, 8'h6f);
      chk(ext_reg, 8'h70);
      op_status <= 4'h5;
      tick(3);
      chk(ext_reg, 8'h75);
      // clock enable low must freeze the read view even though the flags move
      ce <= 1'b0;
      op_status <= 4'h9;
      tick(3);
      chk(ext_reg, 8'h75);
      ce <= 1'b1;
      tick(3);
      chk(ext_reg, 8'h79);
      op_status <= 4'h5;
      ext_wr(8'h85, 8'h3f);
      chk(ext_persist, 8'h30);
      chk(ext_reg, 8'h75);
      // second reset mid-run restores the power-up view
      rst <= 1'b1;
      tick(2);
      rst <= 1'b0;
      tick(4);
      chk(ext_reg, 8'hf5);
      chk({5'h0, drive_strength}, 8'h07);
      end_sim();
   end
endmodule // rlc_top_tb_top
`default_nettype wire
